// File: common/twrs_pkg.sv
/*
 * shared constants and types for the two-wire register slave and its master.
 * assumes a 20 MHz system clock on both ends and external pull-ups on the bus.
 */
package twrs_pkg;
    // ********************************************************
    // address and pointer
    // ********************************************************
    localparam logic [4:0] TWRS_ADDR_FIXED = 5'h13;
    localparam logic [7:0] TWRS_PTR_MAX = 8'h1D;
    localparam logic [7:0] TWRS_PTR_RST = 8'h00;
    localparam logic [7:0] TWRS_REG_RST = 8'h00;
    localparam int TWRS_NUM_REGS = 30;
    // ********************************************************
    // timing
    // ********************************************************
    localparam int TWRS_SYS_CLK_HZ = 20000000;
    localparam int TWRS_SCL_PERIOD_NS = 400;
    localparam int TWRS_SCL_QTR_CYC =
        (TWRS_SCL_PERIOD_NS * (TWRS_SYS_CLK_HZ / 1000000)) / 4000;
    localparam int TWRS_FILT_LEN = 3;
    // ********************************************************
    // master command codes
    // ********************************************************
    typedef enum logic [1:0] {
        TWRS_CMD_WRITE,
        TWRS_CMD_READ
    } twrs_cmd_t;
endpackage

// File: common/twrs_bus_if.sv
/*
 * the two-wire bus between master and slave.
 * assumes open-drain wiring: a line is low when any end enables its driver.
 */
`timescale 1ns/1ps
interface twrs_bus_if;
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;
    // pull-up resolution; drivers only ever pull low
    assign scl = ~(scl_oe_m & ~scl_o_m);
    assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
    modport slave (
        input scl, sda,
        output sda_o_s, sda_oe_s
    );
    modport master (
        input scl, sda,
        output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m
    );
endinterface

// File: logic/twrs_slave.sv
/*
 * two-wire register slave: address match, pointer, 30 8-bit registers.
 * assumes scl/sda are asynchronous to sys_clk_i and the master obeys
 * the bus framing; register outputs feed the rest of the device.
 */
`timescale 1ns/1ps
// Function
// - match 10011 plus two select pins
// - first byte: address then direction bit
// - ack on ninth pulse when matched
// - sda changes only while scl low
// - sda fall with scl high starts
// - sda rise with scl high stops
// - bytes shifted msb first
// - write: second byte loads pointer
// - pointer advances per byte, holds 1Dh
// - no ack for pointer above 1Dh
// - no ack: sda stays released
// - read nack ends data, release sda
// - read starts at written pointer
// - master writes pointer, then restart read
// - repeated start restarts address decode
// - only pull sda low or release
module twrs_slave (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // straps
    input wire logic [1:0] address_select_pins_i,
    // bus
    twrs_bus_if.slave bus,
    // register view
    output logic [7:0] reg_data_o [twrs_pkg::TWRS_NUM_REGS],
    output logic [7:0] ptr_o,
    output logic busy_o
);
    import twrs_pkg::*;

    typedef enum {
        TWRS_S_IDLE, TWRS_S_ADDR, TWRS_S_ACK, TWRS_S_PTR, TWRS_S_WDATA,
        TWRS_S_RDATA, TWRS_S_RACK, TWRS_S_WAIT
    } twrs_sst_t;

    // ********************************************************
    // input synchroniser and filter
    // ********************************************************
    logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
    logic [TWRS_FILT_LEN-1:0] scl_hist_q, scl_hist_d;
    logic [TWRS_FILT_LEN-1:0] sda_hist_q, sda_hist_d;
    logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;

    always_comb begin
        scl_sync_d = {scl_sync_q[0], bus.scl};
        sda_sync_d = {sda_sync_q[0], bus.sda};
        scl_hist_d = {scl_hist_q[TWRS_FILT_LEN-2:0], scl_sync_q[1]};
        sda_hist_d = {sda_hist_q[TWRS_FILT_LEN-2:0], sda_sync_q[1]};
        scl_f_d = scl_f_q;
        sda_f_d = sda_f_q;
        // a level is taken only once stable for the whole history
        if (&scl_hist_q) scl_f_d = 1'b1;
        if (~|scl_hist_q) scl_f_d = 1'b0;
        if (&sda_hist_q) sda_f_d = 1'b1;
        if (~|sda_hist_q) sda_f_d = 1'b0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_hist_q <= '1;
            sda_hist_q <= '1;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_hist_q <= scl_hist_d;
            sda_hist_q <= sda_hist_d;
            scl_f_q <= scl_f_d;
            sda_f_q <= sda_f_d;
        end
    end

    wire scl_rise = scl_f_d & ~scl_f_q;
    wire scl_fall = ~scl_f_d & scl_f_q;
    // sda moving while scl is high is framing, not data
    wire start_ev = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
    wire stop_ev = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

    // ********************************************************
    // protocol engine
    // ********************************************************
    twrs_sst_t st_q, st_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic rd_q, rd_d, ack_q, ack_d, drv_q, drv_d, first_q, first_d;
    logic [7:0] regs_q [TWRS_NUM_REGS];
    logic [7:0] regs_d [TWRS_NUM_REGS];

    function automatic logic [7:0] twrs_inc(input logic [7:0] p);
        return (p >= TWRS_PTR_MAX) ? TWRS_PTR_MAX : p + 8'h01;
    endfunction

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        ack_d = ack_q;
        drv_d = drv_q;
        first_d = first_q;
        regs_d = regs_q;
        if (stop_ev) begin
            st_d = TWRS_S_IDLE;
            drv_d = 1'b0;
        end else if (start_ev) begin
            st_d = TWRS_S_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end else begin
            case (st_q)
                TWRS_S_IDLE: begin
                    drv_d = 1'b0;
                end
                TWRS_S_ADDR, TWRS_S_PTR, TWRS_S_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_f_q};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall && cnt_q == 4'h8) begin
                        ack_d = 1'b1;
                        if (st_q == TWRS_S_ADDR) begin
                            ack_d = (sh_q[7:1] ==
                                {TWRS_ADDR_FIXED, address_select_pins_i});
                            rd_d = sh_q[0];
                            first_d = 1'b1;
                        end else if (st_q == TWRS_S_PTR) begin
                            ack_d = (sh_q <= TWRS_PTR_MAX);
                            if (sh_q <= TWRS_PTR_MAX) ptr_d = sh_q;
                        end else begin
                            regs_d[ptr_q[4:0]] = sh_q;
                            ptr_d = twrs_inc(ptr_q);
                        end
                        drv_d = ack_d;
                        st_d = ack_d ? TWRS_S_ACK : TWRS_S_WAIT;
                    end
                end
                TWRS_S_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        drv_d = 1'b0;
                        if (first_q && rd_q) begin
                            sh_d = regs_q[ptr_q[4:0]];
                            drv_d = ~regs_q[ptr_q[4:0]][7];
                            st_d = TWRS_S_RDATA;
                        end else begin
                            st_d = first_q ? TWRS_S_PTR : TWRS_S_WDATA;
                        end
                        first_d = 1'b0;
                    end
                end
                TWRS_S_RDATA: begin
                    if (scl_fall) begin
                        cnt_d = cnt_q + 4'h1;
                        sh_d = {sh_q[6:0], 1'b0};
                        drv_d = ~sh_q[6];
                        if (cnt_q == 4'h7) begin
                            drv_d = 1'b0;
                            ptr_d = twrs_inc(ptr_q);
                            st_d = TWRS_S_RACK;
                        end
                    end
                end
                TWRS_S_RACK: begin
                    if (scl_rise) ack_d = ~sda_f_q;
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (ack_q) begin
                            sh_d = regs_q[ptr_q[4:0]];
                            drv_d = ~regs_q[ptr_q[4:0]][7];
                            st_d = TWRS_S_RDATA;
                        end else begin
                            st_d = TWRS_S_WAIT;
                        end
                    end
                end
                TWRS_S_WAIT: begin
                    // released until stop or repeated start
                    if (scl_fall) drv_d = 1'b0;
                end
                default: st_d = TWRS_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= TWRS_S_IDLE;
            sh_q <= 8'h00;
            ptr_q <= TWRS_PTR_RST;
            cnt_q <= 4'h0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            first_q <= 1'b0;
            for (int i = 0; i < TWRS_NUM_REGS; i++) regs_q[i] <= TWRS_REG_RST;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            drv_q <= drv_d;
            first_q <= first_d;
            regs_q <= regs_d;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign bus.sda_o_s = 1'b0;
    assign bus.sda_oe_s = drv_q;
    assign reg_data_o = regs_q;
    assign ptr_o = ptr_q;
    assign busy_o = (st_q != TWRS_S_IDLE);
endmodule

// File: logic/twrs_master.sv
/*
 * two-wire master: writes or reads bursts of registers in the slave.
 * assumes one command at a time, held while busy_o is high.
 */
`timescale 1ns/1ps
module twrs_master #(
    parameter int QTR = twrs_pkg::TWRS_SCL_QTR_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // command
    input wire logic cmd_valid_i,
    input twrs_pkg::twrs_cmd_t cmd_i,
    input wire logic [6:0] slave_addr_i,
    input wire logic [7:0] ptr_i,
    input wire logic [3:0] len_i,
    input wire logic [7:0] wdata_i,
    output logic wdata_take_o,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic nack_o,
    output logic busy_o,
    // bus
    twrs_bus_if.master bus
);
    import twrs_pkg::*;

    if (QTR < 1) begin : g_qtr_check
        $error("twrs_master: QTR must be at least 1");
    end

    typedef enum {
        TWRS_M_IDLE, TWRS_M_START, TWRS_M_BYTE, TWRS_M_STOP
    } twrs_mst_t;

    logic sda_s1_q, sda_s2_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    twrs_mst_t st_q, st_d;
    logic [15:0] div_q, div_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d, left_q, left_d;
    logic [1:0] byte_q, byte_d;
    logic [8:0] sh_q, sh_d;
    logic scl_q, scl_d, sda_q, sda_d, rd_q, rd_d, rs_q, rs_d;
    logic [7:0] rdat_q, rdat_d;
    logic rv_q, rv_d, nk_q, nk_d, tk_d;
    wire tick = (div_q == 16'(QTR - 1));

    always_comb begin
        st_d = st_q; div_d = tick ? 16'h0000 : div_q + 16'h0001;
        ph_d = ph_q; bit_d = bit_q; left_d = left_q; byte_d = byte_q;
        sh_d = sh_q; scl_d = scl_q; sda_d = sda_q; rd_d = rd_q; rs_d = rs_q;
        rdat_d = rdat_q; rv_d = 1'b0; nk_d = nk_q; tk_d = 1'b0;
        case (st_q)
            TWRS_M_IDLE: begin
                scl_d = 1'b1; sda_d = 1'b1; div_d = 16'h0000; ph_d = 2'h0;
                if (cmd_valid_i) begin
                    rd_d = (cmd_i == TWRS_CMD_READ); rs_d = 1'b0;
                    left_d = len_i; byte_d = 2'h0; nk_d = 1'b0;
                    st_d = TWRS_M_START;
                end
            end
            TWRS_M_START: if (tick) begin
                ph_d = ph_q + 2'h1;
                // scl rises only once sda is free, so a repeated start
                // never looks like a stop to the slave
                case (ph_q)
                    2'h0: sda_d = 1'b1;
                    2'h1: scl_d = 1'b1;
                    2'h2: sda_d = 1'b0;
                    default: begin
                        scl_d = 1'b0;
                        sh_d = {slave_addr_i, rs_q, 1'b1};
                        bit_d = 4'h0; ph_d = 2'h0; st_d = TWRS_M_BYTE;
                    end
                endcase
            end
            TWRS_M_BYTE: if (tick) begin
                ph_d = ph_q + 2'h1;
                case (ph_q)
                    2'h0: sda_d = sh_q[8];
                    2'h1: scl_d = 1'b1;
                    2'h2: sh_d = {sh_q[7:0], sda_s2_q};
                    default: begin
                        scl_d = 1'b0; bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                            bit_d = 4'h0;
                            byte_d = (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
                            if (!(rs_q && byte_q != 2'h0) && sh_q[0]) begin
                                nk_d = 1'b1; st_d = TWRS_M_STOP;
                            end else if (rs_q && byte_q != 2'h0) begin
                                rdat_d = sh_q[8:1]; rv_d = 1'b1;
                                left_d = left_q - 4'h1;
                                sh_d = {8'hFF, 1'b1};
                                if (left_q == 4'h1) st_d = TWRS_M_STOP;
                                if (left_q == 4'h2) sh_d = 9'h1FF;
                                else sh_d = {8'hFF, 1'b1};
                            end else if (byte_q == 2'h0) begin
                                sh_d = {ptr_i, 1'b1};
                            end else if (rd_q) begin
                                rs_d = 1'b1; byte_d = 2'h0;
                                st_d = TWRS_M_START;
                            end else if (left_q == 4'h0) begin
                                st_d = TWRS_M_STOP;
                            end else begin
                                sh_d = {wdata_i, 1'b1}; tk_d = 1'b1;
                                left_d = left_q - 4'h1;
                            end
                            if (rs_q && byte_q == 2'h0) begin
                                sh_d = (left_q == 4'h1) ? 9'h1FF : 9'h1FE;
                            end
                        end else if (bit_q == 4'h7 && rs_q &&
                                     byte_q != 2'h0) begin
                            // keep the samples; only the ack bit is set
                            sh_d = {(left_q == 4'h1), sh_q[7:0]};
                        end
                    end
                endcase
            end
            TWRS_M_STOP: if (tick) begin
                ph_d = ph_q + 2'h1;
                case (ph_q)
                    2'h0: sda_d = 1'b0;
                    2'h1: scl_d = 1'b1;
                    2'h2: sda_d = 1'b1;
                    default: st_d = TWRS_M_IDLE;
                endcase
            end
            default: st_d = TWRS_M_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= TWRS_M_IDLE; div_q <= 16'h0000; ph_q <= 2'h0;
            bit_q <= 4'h0; left_q <= 4'h0; byte_q <= 2'h0; sh_q <= 9'h1FF;
            scl_q <= 1'b1; sda_q <= 1'b1; rd_q <= 1'b0; rs_q <= 1'b0;
            rdat_q <= 8'h00; rv_q <= 1'b0; nk_q <= 1'b0;
        end else begin
            st_q <= st_d; div_q <= div_d; ph_q <= ph_d;
            bit_q <= bit_d; left_q <= left_d; byte_q <= byte_d; sh_q <= sh_d;
            scl_q <= scl_d; sda_q <= sda_d; rd_q <= rd_d; rs_q <= rs_d;
            rdat_q <= rdat_d; rv_q <= rv_d; nk_q <= nk_d;
        end
    end

    // open drain: only ever pull low
    assign bus.scl_o_m = 1'b0;
    assign bus.scl_oe_m = ~scl_q;
    assign bus.sda_o_m = 1'b0;
    assign bus.sda_oe_m = ~sda_q;
    assign wdata_take_o = tk_d;
    assign rdata_o = rdat_q;
    assign rdata_valid_o = rv_q;
    assign nack_o = nk_q;
    assign busy_o = (st_q != TWRS_M_IDLE);
endmodule

// File: tb/twrs_assertions.sv
/*
 * checker for the two-wire bus between master and slave.
 * assumes the bus signals of the interface, the slave straps, and a
 * master running with a quarter period of four clocks.
 */
`timescale 1ns/1ps
module twrs_assertions
    import twrs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // straps
    input wire logic [1:0] address_select_pins_i,
    // bus
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o_m,
    input wire logic sda_o_m,
    input wire logic sda_o_s,
    input wire logic sda_oe_s
);
    // ********************************************************
    // frame tracking
    // ********************************************************
    logic scl_q, sda_q, first_q, first_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic start_w, stop_w, rise_w, fall_w, ack_due, match;
    always_comb begin
        start_w = scl && scl_q && sda_q && !sda;
        stop_w = scl && scl_q && !sda_q && sda;
        rise_w = scl && !scl_q;
        fall_w = !scl && scl_q;
        first_d = first_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        if (start_w) begin
            first_d = 1'b1;
            cnt_d = 4'h0;
        end else if (stop_w) begin
            first_d = 1'b0;
        end else if (rise_w && cnt_q < 4'h9) begin
            cnt_d = cnt_q + 4'h1;
            sh_d = {sh_q[6:0], sda};
        end else if (fall_w && cnt_q == 4'h9) begin
            cnt_d = 4'h0;
            first_d = 1'b0;
        end
        ack_due = first_q && cnt_q == 4'h8 && fall_w;
        match = sh_q[7:1] == {TWRS_ADDR_FIXED, address_select_pins_i};
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            first_q <= first_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
        end
    end
    // ********************************************************
    // properties
    // ********************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_pull_only; sda_o_s == 1'b0; endproperty
    property p_master_pull_only;
        scl_o_m == 1'b0 && sda_o_m == 1'b0;
    endproperty
    property p_reset_release; $fell(rst_i) |-> !sda_oe_s; endproperty
    property p_oe_scl_low; $changed(sda_oe_s) |-> !scl; endproperty
    property p_addr_quiet; first_q && sda_oe_s |-> cnt_q >= 4'h8; endproperty
    // ack must land inside the low half before the ninth pulse
    property p_ack_match; ack_due && match |-> ##[1:8] sda_oe_s; endproperty
    property p_no_ack; ack_due && !match |-> !sda_oe_s [*8]; endproperty
    property p_stop_release; stop_w |=> !sda_oe_s [*8]; endproperty
    property p_start_not_slave; start_w |-> !sda_oe_s; endproperty
    a_pull_only: assert property (p_pull_only)
        else $error("slave drives sda high");
    a_master_pull_only: assert property (p_master_pull_only)
        else $error("master drives a line high");
    a_reset_release: assert property (p_reset_release)
        else $error("slave holds sda after reset");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("slave sda changed while scl high");
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("slave drove sda during address bits");
    a_ack_match: assert property (p_ack_match)
        else $error("no ack on matching address");
    a_no_ack: assert property (p_no_ack)
        else $error("ack on foreign address");
    a_stop_release: assert property (p_stop_release)
        else $error("sda held after stop");
    a_start_not_slave: assert property (p_start_not_slave)
        else $error("start caused by slave");
    c_ack_match: cover property (ack_due && match);
    c_no_ack: cover property (ack_due && !match);
    c_stop: cover property (stop_w);
endmodule

// File: tb/tb_top.sv
/*
 * testbench: master and slave joined by one bus interface.
 * assumes the master moves whole bursts and flags a missing ack on nack_o.
 */
`timescale 1ns/1ps
module tb_top;
    import twrs_pkg::*;
    // ********************************************************
    // signals
    // ********************************************************
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    twrs_cmd_t cmd_i = TWRS_CMD_WRITE;
    logic [6:0] slave_addr_i = 7'h00;
    logic [7:0] ptr_i = 8'h00;
    logic [3:0] len_i = 4'h0;
    logic [7:0] wdata_i;
    logic [1:0] sel = 2'h2;
    logic wdata_take_o, rdata_valid_o, nack_o, m_busy, s_busy;
    logic [7:0] rdata_o, ptr_o;
    logic [7:0] reg_data_o [TWRS_NUM_REGS];
    logic [7:0] wbuf [16];
    logic [7:0] rbuf [16];
    logic [7:0] wsh = 8'h00;
    int widx = 0;
    int ridx = 0;
    int wcnt = 8;
    int bad_count = 0;
    int n_checks = 0;
    twrs_bus_if bus ();
    assign wdata_i = wbuf[widx[3:0]];
    // ********************************************************
    // instances
    // ********************************************************
    twrs_slave twrs_slave_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .address_select_pins_i(sel), .bus(bus.slave),
        .reg_data_o(reg_data_o), .ptr_o(ptr_o), .busy_o(s_busy));
    // wider quarter gives the slave filter its margin
    twrs_master #(.QTR(4)) twrs_master_inst (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .slave_addr_i(slave_addr_i), .ptr_i(ptr_i), .len_i(len_i),
        .wdata_i(wdata_i), .wdata_take_o(wdata_take_o),
        .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
        .nack_o(nack_o), .busy_o(m_busy), .bus(bus.master));
    twrs_assertions twrs_assertions_inst (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .address_select_pins_i(sel), .scl(bus.scl),
        .sda(bus.sda), .scl_o_m(bus.scl_o_m), .sda_o_m(bus.sda_o_m),
        .sda_o_s(bus.sda_o_s), .sda_oe_s(bus.sda_oe_s));
    // ********************************************************
    // clock, data feed, wire monitor
    // ********************************************************
    initial forever #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (wdata_take_o === 1'b1) widx <= widx + 1;
        if (rdata_valid_o === 1'b1) begin
            rbuf[ridx[3:0]] <= rdata_o;
            ridx <= ridx + 1;
        end
    end
    // first byte after the latest start, as seen on the wire
    always @(negedge bus.sda) if (bus.scl === 1'b1) wcnt = 0;
    always @(posedge bus.scl) begin
        if (wcnt < 8) begin
            wsh = {wsh[6:0], bus.sda};
            wcnt = wcnt + 1;
        end
    end
    // ********************************************************
    // tasks
    // ********************************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input twrs_cmd_t c, input logic [6:0] a,
                       input logic [7:0] p, input logic [3:0] n);
        int t;
        t = 0;
        @(posedge sys_clk_i);
        widx <= 0;
        ridx <= 0;
        cmd_i <= c;
        slave_addr_i <= a;
        ptr_i <= p;
        len_i <= n;
        cmd_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        while (m_busy !== 1'b0 && t < 4000) begin
            @(posedge sys_clk_i);
            #1;
            t++;
        end
        if (t >= 4000) bad_count++;
        // let the slave see the stop before the next start
        repeat (20) @(posedge sys_clk_i);
        check("slave_idle", {7'h00, s_busy}, 8'h00);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        bad_count++;
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 16; i++) wbuf[i] = 8'hA0 + 8'(i);
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check("ptr_reset", ptr_o, TWRS_PTR_RST);
        check("reg_reset", reg_data_o[29], TWRS_REG_RST);
        $display("test reset done");
        // four bytes from 1Bh: last two land on 1Dh
        run(TWRS_CMD_WRITE, {TWRS_ADDR_FIXED, sel}, 8'h1B, 4'h4);
        check("nack_write", {7'h00, nack_o}, 8'h00);
        check("wire_addr_w", wsh, {TWRS_ADDR_FIXED, sel, 1'b0});
        check("reg_1b", reg_data_o[27], 8'hA0);
        check("reg_1c", reg_data_o[28], 8'hA1);
        check("reg_1d", reg_data_o[29], 8'hA3);
        check("ptr_sat", ptr_o, TWRS_PTR_MAX);
        $display("test burst write done");
        run(TWRS_CMD_READ, {TWRS_ADDR_FIXED, sel}, 8'h1B, 4'h3);
        check("wire_addr_r", wsh, {TWRS_ADDR_FIXED, sel, 1'b1});
        check("rd_count", 8'(ridx), 8'h03);
        check("rd_0", rbuf[0], 8'hA0);
        check("rd_1", rbuf[1], 8'hA1);
        check("rd_2", rbuf[2], 8'hA3);
        $display("test read restart done");
        // every select value; only the strapped one answers
        for (int a = 0; a < 4; a++) begin
            run(TWRS_CMD_WRITE, {TWRS_ADDR_FIXED, 2'(a)}, 8'h05, 4'h1);
            check("nack_sel", {7'h00, nack_o}, {7'h00, 2'(a) != sel});
            check("reg_05", reg_data_o[5], (a < 2) ? 8'h00 : 8'hA0);
        end
        $display("test address select done");
        run(TWRS_CMD_READ, {TWRS_ADDR_FIXED, sel}, 8'h05, 4'h1);
        check("rd1_count", 8'(ridx), 8'h01);
        check("rd1_0", rbuf[0], 8'hA0);
        $display("test single read done");
        run(TWRS_CMD_WRITE, {TWRS_ADDR_FIXED, sel}, 8'h1E, 4'h1);
        check("nack_ptr", {7'h00, nack_o}, 8'h01);
        check("ptr_kept", ptr_o, 8'h06);
        check("reg_1d_kept", reg_data_o[29], 8'hA3);
        $display("test pointer limit done");
        end_of_test();
    end
endmodule
